// >>> hdl/ulms_regs.svh
`ifndef ULMS_REGS_SVH
`define ULMS_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ULMS_OFS_RXDATA 8'h00
`define ULMS_OFS_CONFIG 8'h08
`define ULMS_OFS_MCTRL  8'h10
`define ULMS_OFS_LSTAT  8'h14
`define ULMS_OFS_MSTAT  8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ULMS_LS_DR      0
`define ULMS_LS_OE      1
`define ULMS_LS_PE      2
`define ULMS_MC_DTR     0
`define ULMS_MC_RTS     1
`define ULMS_MC_OP1     2
`define ULMS_MC_OP2     3
`define ULMS_MC_LOOP    4
`define ULMS_CFG_FIFO   0
`define ULMS_MS_LVL     4

// ----------------------------------------------------------------
// Reset values, sizes, responses
// ----------------------------------------------------------------
`define ULMS_MCTRL_RST  5'h00
`define ULMS_EFC_RST    3'h0
`define ULMS_CFG_RST    1'b0
`define ULMS_RX_DEPTH   128
`define ULMS_RESP_OKAY  2'h0
`define ULMS_RESP_SLV   2'h2

`endif

// >>> hdl/ulms_pkg.sv
package ulms_pkg;

  typedef logic [7:0] ulms_addr_t;

  typedef struct packed {
    logic       perr;
    logic [7:0] data;
  } ulms_char_s;

  // Order matches modem status bits 7..4
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } ulms_modem_s;

  typedef enum logic [0:0] {
    WR_IDLE,
    WR_RESP
  } ulms_wr_e;

  function automatic logic ulms_hit(input ulms_addr_t a, input ulms_addr_t ofs);
    return a[7:2] == ofs[7:2];
  endfunction : ulms_hit

endpackage : ulms_pkg

// >>> hdl/ulms_sync.sv
`timescale 1ns/1ps

module ulms_sync #(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         i_clk,  // Clock
  input  wire logic         i_rst,  // Async reset
  input  wire logic [W-1:0] i_d,    // Async levels
  output logic      [W-1:0] o_q     // Synchronised levels
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_r <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end

endmodule : ulms_sync

// >>> hdl/ulms_rx_status.sv
`timescale 1ns/1ps

module ulms_rx_status #(
  parameter int DEPTH = 128,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic                 i_clk,     // Clock
  input  wire logic                 i_rst,     // Async reset
  input  wire logic                 i_flush,   // Empty the queue
  input  wire logic                 i_fifo_en, // Queue mode, else one holding slot
  input  wire logic                 i_push,    // Character completed
  input  wire ulms_pkg::ulms_char_s i_char,    // Character and parity flag
  input  wire logic                 i_pop,     // Head consumed
  output ulms_pkg::ulms_char_s      o_head,    // Head character
  output logic                      o_ne,      // Not empty
  output logic                      o_ovr,     // Push refused, queue full
  output logic      [AW:0]          o_count    // Fill level
);
  import ulms_pkg::*;

  ulms_char_s  mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic [AW:0]   cap;
  logic          full;
  logic          push_ok;
  logic          pop_ok;

  always_comb begin
    cap     = i_fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
    full    = count_r >= cap;
    push_ok = i_push & ~full;
    pop_ok  = i_pop & (count_r != '0);
    o_ovr   = i_push & full;
    o_ne    = count_r != '0;
    o_head  = mem[rd_ptr_r];
    o_count = count_r;
  end

  // Refused character is dropped; queued ones stay intact
  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      mem[wr_ptr_r] <= i_char;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else if (i_flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop_ok) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push_ok & ~pop_ok) begin
        count_r <= count_r + 1'b1;
      end else if (pop_ok & ~push_ok) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule : ulms_rx_status

// >>> hdl/ulms_top.sv
`timescale 1ns/1ps
`include "ulms_regs.svh"

// ----------------------------------------------------------------
// What this block does
// - Parity failure sets line status bit 2
// - Queue mode: parity flag follows head character
// - Character into full queue sets bit 1
// - Overrun drops new character, queue kept
// - Bit 0 high while characters remain
// - Error and change flags zero after reset
// - Modem status read-only; write hits extra_feature_control
// - CD, DSR, CTS toggles set bits 3,1,0
// - RI change flag only on trailing edge
// - Reading modem status clears four change flags
// - Any change flag raises modem interrupt
// - Bit 7: CD, loopback user_output_two
// - Bit 6: RI, loopback user_output_one
// - Bit 5: DSR, loopback DTR bit
// - Bit 4: CTS, loopback RTS bit
// ----------------------------------------------------------------
module ulms_top #(
  parameter int RX_DEPTH = `ULMS_RX_DEPTH
) (
  input  wire logic                  I_REF_CLK,   // 50 MHz clock
  input  wire logic                  I_RST,       // Async reset, high
  input  wire ulms_pkg::ulms_addr_t  I_AWADDR,    // Write address
  input  wire logic                  I_AWVALID,   // Write address valid
  output logic                       O_AWREADY,   // Write address ready
  input  wire logic [31:0]           I_WDATA,     // Write data
  input  wire logic [3:0]            I_WSTRB,     // Write strobes
  input  wire logic                  I_WVALID,    // Write data valid
  output logic                       O_WREADY,    // Write data ready
  output logic      [1:0]            O_BRESP,     // Write response
  output logic                       O_BVALID,    // Write response valid
  input  wire logic                  I_BREADY,    // Write response ready
  input  wire ulms_pkg::ulms_addr_t  I_ARADDR,    // Read address
  input  wire logic                  I_ARVALID,   // Read address valid
  output logic                       O_ARREADY,   // Read address ready
  output logic      [31:0]           O_RDATA,     // Read data
  output logic      [1:0]            O_RRESP,     // Read response
  output logic                       O_RVALID,    // Read data valid
  input  wire logic                  I_RREADY,    // Read data ready
  input  wire logic                  I_RX_VALID,  // Received character pulse
  input  wire ulms_pkg::ulms_char_s  I_RX_CHAR,   // Received character
  input  wire ulms_pkg::ulms_modem_s I_MODEM_N,   // Modem inputs, active low
  output logic                       O_DTR_N,     // DTR pin, active low
  output logic                       O_RTS_N,     // RTS pin, active low
  output logic                       O_OP1_N,     // User output one, active low
  output logic                       O_OP2_N,     // User output two, active low
  output logic                       O_MODEM_IRQ, // Modem status interrupt
  output logic      [2:0]            O_EXTRA_FEAT // extra_feature_control
);
  import ulms_pkg::*;

  ulms_wr_e       wr_st_r;
  logic           aw_got_r;
  logic           w_got_r;
  ulms_addr_t     waddr_r;
  logic [7:0]     wdata_r;
  logic           wstrb_r;
  logic           aw_fire;
  logic           w_fire;
  logic           aw_have;
  logic           w_have;
  ulms_addr_t     wa_eff;
  logic [7:0]     wd_eff;
  logic           ws_eff;
  logic           wr_do;
  logic           wr_lane;
  logic           ar_fire;
  logic           rd_mstat;
  logic           rd_lstat;
  logic           rd_pop;
  logic [7:0]     rd_val;
  logic [4:0]     mctrl_r;
  logic           cfg_fifo_r;
  logic           cfg_wr;
  logic           loop;
  logic [3:0]     m_sync;
  logic [3:0]     lb_vec;
  logic [3:0]     lvl;
  logic [3:0]     lvl_r;
  logic [3:0]     chg;
  logic [3:0]     set;
  logic [3:0]     delta_r;
  logic [3:0]     delta_nxt;
  logic           oe_r;
  logic           ls_pe;
  logic [7:0]     ls_val;
  ulms_char_s     rx_head;
  logic           rx_ne;
  logic           rx_ovr;
  logic [$clog2(RX_DEPTH):0] rx_count;

  function automatic logic map_hit(input ulms_addr_t a);
    return ulms_hit(a, `ULMS_OFS_RXDATA) | ulms_hit(a, `ULMS_OFS_CONFIG) |
           ulms_hit(a, `ULMS_OFS_MCTRL) | ulms_hit(a, `ULMS_OFS_LSTAT) |
           ulms_hit(a, `ULMS_OFS_MSTAT);
  endfunction : map_hit

  // ----------------------------------------------------------------
  // Modem inputs
  // ----------------------------------------------------------------
  // two-stage synchroniser
  ulms_sync #(
    .W       (4),
    .RST_VAL (4'hf)
  ) u_sync (
    .i_clk (I_REF_CLK),
    .i_rst (I_RST),
    .i_d   (I_MODEM_N),
    .o_q   (m_sync)
  );

  always_comb begin
    loop   = mctrl_r[`ULMS_MC_LOOP];
    lb_vec = {mctrl_r[`ULMS_MC_OP2], mctrl_r[`ULMS_MC_OP1],
              mctrl_r[`ULMS_MC_DTR], mctrl_r[`ULMS_MC_RTS]};
    lvl    = loop ? lb_vec : ~m_sync;
    chg    = lvl ^ lvl_r;
    set    = {chg[3], lvl_r[2] & ~lvl[2], chg[1], chg[0]};
    // clear on read, new change wins
    delta_nxt = (rd_mstat ? 4'h0 : delta_r) | set;
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      lvl_r   <= 4'h0;
      delta_r <= 4'h0;
    end else begin
      lvl_r   <= lvl;
      delta_r <= delta_nxt;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MODEM_IRQ <= 1'b0;
    end else begin
      O_MODEM_IRQ <= |delta_nxt;
    end
  end

  // Pins held inactive while looped back
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_DTR_N <= 1'b1;
      O_RTS_N <= 1'b1;
      O_OP1_N <= 1'b1;
      O_OP2_N <= 1'b1;
    end else begin
      O_DTR_N <= loop | ~mctrl_r[`ULMS_MC_DTR];
      O_RTS_N <= loop | ~mctrl_r[`ULMS_MC_RTS];
      O_OP1_N <= loop | ~mctrl_r[`ULMS_MC_OP1];
      O_OP2_N <= loop | ~mctrl_r[`ULMS_MC_OP2];
    end
  end

  // ----------------------------------------------------------------
  // Receive status
  // ----------------------------------------------------------------
  // full queue refuses the character
  ulms_rx_status #(
    .DEPTH (RX_DEPTH)
  ) u_rx (
    .i_clk     (I_REF_CLK),
    .i_rst     (I_RST),
    .i_flush   (cfg_wr),
    .i_fifo_en (cfg_fifo_r),
    .i_push    (I_RX_VALID),
    .i_char    (I_RX_CHAR),
    .i_pop     (rd_pop),
    .o_head    (rx_head),
    .o_ne      (rx_ne),
    .o_ovr     (rx_ovr),
    .o_count   (rx_count)
  );

  // sticky overrun, set wins over read clear
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= (oe_r & ~rd_lstat) | rx_ovr;
    end
  end

  always_comb begin
    ls_pe  = rx_ne & rx_head.perr;
    ls_val = 8'h00;
    // data ready while queue holds data
    ls_val[`ULMS_LS_DR] = rx_ne;
    ls_val[`ULMS_LS_OE] = oe_r;
    ls_val[`ULMS_LS_PE] = ls_pe;
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    aw_fire = I_AWVALID & O_AWREADY;
    w_fire  = I_WVALID & O_WREADY;
    aw_have = aw_got_r | aw_fire;
    w_have  = w_got_r | w_fire;
    wa_eff  = aw_fire ? I_AWADDR : waddr_r;
    wd_eff  = w_fire ? I_WDATA[7:0] : wdata_r;
    ws_eff  = w_fire ? I_WSTRB[0] : wstrb_r;
    wr_do   = (wr_st_r == WR_IDLE) & aw_have & w_have;
    wr_lane = wr_do & ws_eff;
    cfg_wr  = wr_lane & ulms_hit(wa_eff, `ULMS_OFS_CONFIG);
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      wr_st_r   <= WR_IDLE;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= `ULMS_RESP_OKAY;
    end else begin
      case (wr_st_r)
        WR_IDLE: begin
          if (wr_do) begin
            wr_st_r   <= WR_RESP;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            O_BVALID  <= 1'b1;
            O_BRESP   <= map_hit(wa_eff) ? `ULMS_RESP_OKAY : `ULMS_RESP_SLV;
          end else begin
            aw_got_r  <= aw_have;
            w_got_r   <= w_have;
            O_AWREADY <= ~aw_have;
            O_WREADY  <= ~w_have;
          end
        end
        WR_RESP: begin
          if (I_BREADY) begin
            wr_st_r   <= WR_IDLE;
            O_BVALID  <= 1'b0;
            O_AWREADY <= 1'b1;
            O_WREADY  <= 1'b1;
          end
        end
        default: begin
          wr_st_r <= WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      waddr_r <= 8'h00;
      wdata_r <= 8'h00;
      wstrb_r <= 1'b0;
    end else begin
      if (aw_fire) begin
        waddr_r <= I_AWADDR;
      end
      if (w_fire) begin
        wdata_r <= I_WDATA[7:0];
        wstrb_r <= I_WSTRB[0];
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      mctrl_r      <= `ULMS_MCTRL_RST;
      cfg_fifo_r   <= `ULMS_CFG_RST;
      O_EXTRA_FEAT <= `ULMS_EFC_RST;
    end else if (wr_lane) begin
      if (ulms_hit(wa_eff, `ULMS_OFS_MCTRL)) begin
        mctrl_r <= wd_eff[4:0];
      end
      if (ulms_hit(wa_eff, `ULMS_OFS_CONFIG)) begin
        cfg_fifo_r <= wd_eff[`ULMS_CFG_FIFO];
      end
      if (ulms_hit(wa_eff, `ULMS_OFS_MSTAT)) begin
        O_EXTRA_FEAT <= wd_eff[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    ar_fire  = I_ARVALID & O_ARREADY;
    rd_mstat = ar_fire & ulms_hit(I_ARADDR, `ULMS_OFS_MSTAT);
    rd_lstat = ar_fire & ulms_hit(I_ARADDR, `ULMS_OFS_LSTAT);
    rd_pop   = ar_fire & ulms_hit(I_ARADDR, `ULMS_OFS_RXDATA);
    rd_val   = 8'h00;
    if (ulms_hit(I_ARADDR, `ULMS_OFS_RXDATA)) begin
      rd_val = rx_ne ? rx_head.data : 8'h00;
    end else if (ulms_hit(I_ARADDR, `ULMS_OFS_CONFIG)) begin
      rd_val = {7'h00, cfg_fifo_r};
    end else if (ulms_hit(I_ARADDR, `ULMS_OFS_MCTRL)) begin
      rd_val = {3'h0, mctrl_r};
    end else if (ulms_hit(I_ARADDR, `ULMS_OFS_LSTAT)) begin
      rd_val = ls_val;
    end else if (ulms_hit(I_ARADDR, `ULMS_OFS_MSTAT)) begin
      rd_val = {lvl_r, delta_r};
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= `ULMS_RESP_OKAY;
    end else if (ar_fire) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RDATA   <= {24'h00_0000, rd_val};
      O_RRESP   <= map_hit(I_ARADDR) ? `ULMS_RESP_OKAY : `ULMS_RESP_SLV;
    end else if (O_RVALID & I_RREADY) begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b1;
    end else if (~O_RVALID) begin
      O_ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  sequence s_push_clean;
    I_RX_VALID & ~rd_pop & ~cfg_wr;
  endsequence

  sequence s_msr_read_quiet;
    rd_mstat & (set == 4'h0);
  endsequence

  a_perr_shown: assert property ((s_push_clean and (~rx_ne & I_RX_CHAR.perr)) |=> ls_pe)
    else $error("parity flag not set for suspect character");
  a_perr_head: assert property ((s_push_clean and (rx_ne & ~rx_head.perr & I_RX_CHAR.perr)) |=> ~ls_pe)
    else $error("parity flag taken from queued character");
  a_ovr_flag: assert property (rx_ovr |=> oe_r ##1 (oe_r | $past(rd_lstat)))
    else $error("overrun flag not held");
  a_ovr_keep: assert property ((rx_ovr & ~rd_pop & ~cfg_wr) |=> $stable(rx_count) && $stable(rx_head))
    else $error("overrun disturbed queue contents");
  a_dr_drop: assert property (((rx_count == 1) & rd_pop & ~I_RX_VALID & ~cfg_wr) |=> ~ls_val[`ULMS_LS_DR])
    else $error("data ready stayed high with nothing left");
  a_reset_zero: assert property ($past(I_RST) |-> (delta_r == 4'h0) && ~oe_r && ~rx_ne && ~O_MODEM_IRQ)
    else $error("flags not zero after reset");
  a_efc_write: assert property ((wr_lane & ulms_hit(wa_eff, `ULMS_OFS_MSTAT)) |=> O_EXTRA_FEAT == $past(wd_eff[2:0]))
    else $error("shared address write missed extra_feature_control");
  a_tog_delta: assert property (((chg & 4'hb) != 4'h0) |=> (delta_r & $past(chg & 4'hb)) == $past(chg & 4'hb))
    else $error("toggle did not set its change flag");
  a_ri_trail: assert property ((lvl_r[2] & ~lvl[2]) |=> delta_r[2])
    else $error("ring trailing edge missed");
  a_ri_lead: assert property ((~lvl_r[2] & lvl[2] & ~delta_r[2]) |=> ~delta_r[2])
    else $error("ring leading edge set its flag");
  a_read_clears: assert property (s_msr_read_quiet |=> delta_r == 4'h0)
    else $error("change flags not cleared by read");
  a_irq_level: assert property (O_MODEM_IRQ == (delta_r != 4'h0))
    else $error("modem interrupt disagrees with change flags");
  a_loop_mirror: assert property (loop |=> lvl_r == $past(lb_vec))
    else $error("loopback status bits wrong");
  a_set_wins: assert property ((rd_mstat & (set != 4'h0)) |=> delta_r == $past(set))
    else $error("change during read was lost");
  a_loop_delta: assert property ((loop & (lb_vec[0] != lvl_r[0])) |=> delta_r[0])
    else $error("looped RTS change not flagged");

endmodule : ulms_top

// >>> tb/ulms_modem_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Modem side: active-low control lines, prompt or lagging
// ----------------------------------------------------------------
module ulms_modem_model (
  input  wire logic                  i_clk,    // Clock
  input  wire logic                  i_slow,   // Lag changes by three cycles
  input  wire ulms_pkg::ulms_modem_s i_lvl,    // Wanted active levels
  output ulms_pkg::ulms_modem_s      o_pins_n  // Modem lines, active low
);
  import ulms_pkg::*;

  logic [11:0] lag_r = '1;

  always @(posedge i_clk) begin
    lag_r    <= {lag_r[7:0], ~i_lvl};
    o_pins_n <= i_slow ? lag_r[11:8] : ~i_lvl;
  end
endmodule : ulms_modem_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "ulms_regs.svh"

module testbench;
  import ulms_pkg::*;

  logic        I_REF_CLK, I_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_RX_VALID, slow;
  logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_MODEM_IRQ;
  logic        O_DTR_N, O_RTS_N, O_OP1_N, O_OP2_N;
  logic [1:0]  O_BRESP, O_RRESP;
  logic [2:0]  O_EXTRA_FEAT;
  logic [3:0]  I_WSTRB;
  logic [31:0] I_WDATA, O_RDATA, mask;
  ulms_addr_t  I_AWADDR, I_ARADDR;
  ulms_char_s  I_RX_CHAR;
  ulms_modem_s I_MODEM_N, lvl;
  int          fail_count, n_tests;
  localparam logic [7:0] LOOP_LVL [4] = '{8'h20, 8'h10, 8'h40, 8'h80};

  ulms_top #(.RX_DEPTH(4)) dut (.*);
  ulms_modem_model modem (.i_clk(I_REF_CLK), .i_slow(slow), .i_lvl(lvl), .o_pins_n(I_MODEM_N));

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input ulms_addr_t a, input logic [7:0] d, input logic [1:0] er);
    @(posedge I_REF_CLK);
    I_AWADDR  <= a;
    I_WDATA   <= {24'h0, d};
    I_AWVALID <= 1'b1;
    I_WVALID  <= 1'b1;
    I_BREADY  <= 1'b1;
    forever begin
      @(posedge I_REF_CLK);
      if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
      if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
      if (O_BVALID) break;
    end
    chk({30'h0, O_BRESP}, {30'h0, er});
    I_BREADY <= 1'b0;
  endtask : wr

  task automatic rd(input ulms_addr_t a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge I_REF_CLK);
    I_ARADDR  <= a;
    I_ARVALID <= 1'b1;
    I_RREADY  <= 1'b1;
    forever begin
      @(posedge I_REF_CLK);
      if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
      if (O_RVALID) break;
    end
    chk(O_RDATA & mask, exp);
    chk({30'h0, O_RRESP}, {30'h0, er});
    I_RREADY <= 1'b0;
  endtask : rd

  task automatic rx(input logic [7:0] d, input logic pe);
    @(posedge I_REF_CLK);
    I_RX_CHAR  <= {pe, d};
    I_RX_VALID <= 1'b1;
    @(posedge I_REF_CLK);
    I_RX_VALID <= 1'b0;
  endtask : rx

  task automatic tick(input int n);
    repeat (n) @(posedge I_REF_CLK);
  endtask : tick

  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    I_REF_CLK = 1'b0;
    forever #10 I_REF_CLK = ~I_REF_CLK;
  end

  initial begin
    #400000;
    fail_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_RX_VALID, slow} = '0;
    {I_AWADDR, I_ARADDR, I_WDATA, I_RX_CHAR} = '0;
    I_WSTRB    = 4'hf;
    lvl        = '0;
    mask       = '1;
    fail_count = 0;
    n_tests    = 0;
    I_RST      = 1'b1;
    tick(6);
    I_RST <= 1'b0;
    rd(`ULMS_OFS_LSTAT, 32'h00, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_MSTAT, 32'h00, `ULMS_RESP_OKAY);
    chk({31'h0, O_MODEM_IRQ}, 32'h0);
    rd(8'h04, 32'h00, `ULMS_RESP_SLV);
    wr(8'h04, 8'h11, `ULMS_RESP_SLV);
    // Holding slot: parity, overrun, ready
    rx(8'h5a, 1'b1);
    rd(`ULMS_OFS_LSTAT, 32'h05, `ULMS_RESP_OKAY);
    rx(8'h33, 1'b0);
    rd(`ULMS_OFS_LSTAT, 32'h07, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_RXDATA, 32'h5a, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_LSTAT, 32'h00, `ULMS_RESP_OKAY);
    // Queue mode, filled to refusal
    wr(`ULMS_OFS_CONFIG, 8'h01, `ULMS_RESP_OKAY);
    for (int i = 0; i < 4; i++) rx(8'ha0 + 8'(i), i == 1);
    rd(`ULMS_OFS_LSTAT, 32'h01, `ULMS_RESP_OKAY);
    rx(8'hee, 1'b0);
    rd(`ULMS_OFS_LSTAT, 32'h03, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_RXDATA, 32'ha0, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_LSTAT, 32'h05, `ULMS_RESP_OKAY);
    for (int i = 1; i < 4; i++) rd(`ULMS_OFS_RXDATA, 32'ha0 + i, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_LSTAT, 32'h00, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_RXDATA, 32'h00, `ULMS_RESP_OKAY);
    // Modem lines, slow then prompt
    slow <= 1'b1;
    lvl  <= 4'hb;
    tick(14);
    chk({31'h0, O_MODEM_IRQ}, 32'h1);
    rd(`ULMS_OFS_MSTAT, 32'hbb, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_MSTAT, 32'hb0, `ULMS_RESP_OKAY);
    chk({31'h0, O_MODEM_IRQ}, 32'h0);
    slow <= 1'b0;
    lvl  <= 4'hf;
    tick(6);
    rd(`ULMS_OFS_MSTAT, 32'hf0, `ULMS_RESP_OKAY);
    lvl <= 4'hb;
    tick(6);
    rd(`ULMS_OFS_MSTAT, 32'hb4, `ULMS_RESP_OKAY);
    lvl <= 4'h0;
    tick(6);
    rd(`ULMS_OFS_MSTAT, 32'h0b, `ULMS_RESP_OKAY);
    wr(`ULMS_OFS_MSTAT, 8'hfd, `ULMS_RESP_OKAY);
    chk({29'h0, O_EXTRA_FEAT}, 32'h5);
    // Lane 0 strobe off stores nothing
    I_WSTRB <= 4'he;
    wr(`ULMS_OFS_MSTAT, 8'h02, `ULMS_RESP_OKAY);
    I_WSTRB <= 4'hf;
    chk({29'h0, O_EXTRA_FEAT}, 32'h5);
    rd(`ULMS_OFS_MSTAT, 32'h00, `ULMS_RESP_OKAY);
    // CTS change lands on the read edge
    lvl <= 4'h1;
    tick(2);
    rd(`ULMS_OFS_MSTAT, 32'h00, `ULMS_RESP_OKAY);
    rd(`ULMS_OFS_MSTAT, 32'h11, `ULMS_RESP_OKAY);
    wr(`ULMS_OFS_MCTRL, 8'h03, `ULMS_RESP_OKAY);
    tick(2);
    chk({28'h0, O_OP2_N, O_OP1_N, O_RTS_N, O_DTR_N}, 32'hc);
    // Loopback levels and changes
    wr(`ULMS_OFS_MCTRL, 8'h10, `ULMS_RESP_OKAY);
    wr(`ULMS_OFS_MCTRL, 8'h1f, `ULMS_RESP_OKAY);
    tick(2);
    chk({28'h0, O_OP2_N, O_OP1_N, O_RTS_N, O_DTR_N}, 32'hf);
    rd(`ULMS_OFS_MSTAT, 32'hfb, `ULMS_RESP_OKAY);
    mask = 32'hf0;
    for (int k = 0; k < 4; k++) begin
      wr(`ULMS_OFS_MCTRL, 8'h10 | (8'h01 << k), `ULMS_RESP_OKAY);
      rd(`ULMS_OFS_MSTAT, {24'h0, LOOP_LVL[k]}, `ULMS_RESP_OKAY);
    end
    mask = '1;
    lvl <= 4'hf;
    tick(6);
    rd(`ULMS_OFS_MSTAT, 32'h80, `ULMS_RESP_OKAY);
    finish_test();
  end
endmodule : testbench
